// >>> hdl/rtcc_core.sv
`timescale 1ns/1ps
module rtcc_core #(
   parameter int CARRY_CYC = rtcc_pkg::CARRY_CYCLES
) (
   input  wire logic       clk_sys,
   input  wire logic       sys_rst,
   input  wire logic       slowClkPin,
   input  wire logic [3:0] regAddr,
   input  wire logic [7:0] regWrData,
   input  wire logic       regWr,
   input  wire logic       regRd,
   output logic      [7:0] regRdData,
   output logic            irqAllow,
   output logic            clkSupplyEn
);
   import rtcc_pkg::*;

   if (CARRY_CYC < 2 || CARRY_CYC > 65535) begin : g_chk
      $error("CARRY_CYC out of range");
   end

   localparam logic [15:0] CARRY_LOAD = 16'(CARRY_CYC - 1);

   // ****************************************
   // Control registers
   // ****************************************
   logic       cce_r;
   logic       lvlMode_r;
   logic       srst_r;
   logic       stop_r;
   logic       fmt24_r;
   logic       hold_r;
   logic       snap_r;
   logic       round_r;
   logic       pend_r;
   logic [15:0] busyCnt_r;
   logic [15:0] roundCnt_r;
   logic       busy;
   logic       wrA;
   logic       wrB;
   logic       ctrWr;
   logic       roundStart;
   logic       incSec;
   logic       tick;

   assign busy       = busyCnt_r != 16'h0000;
   assign wrA        = regWr && regAddr == ADDR_CTLA;
   assign wrB        = regWr && regAddr == ADDR_CTLB;
   assign ctrWr      = regWr && regAddr >= ADDR_SEC && regAddr <= ADDR_WEEK;
   assign roundStart = wrA && regWrData[CTLA_ROUND] && !round_r;

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         cce_r     <= 1'b0;
         lvlMode_r <= 1'b0;
      end else if (regWr && regAddr == ADDR_CLKCTL) begin
         cce_r <= regWrData[0];
      end else if (regWr && regAddr == ADDR_IRQMODE) begin
         lvlMode_r <= regWrData[0];
      end
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         srst_r  <= CTLA_RST[CTLA_SRST];
         stop_r  <= CTLA_RST[CTLA_STOP];
         fmt24_r <= CTLA_RST[CTLA_FMT24];
      end else if (wrA) begin
         srst_r  <= regWrData[CTLA_SRST];
         stop_r  <= regWrData[CTLA_STOP];
         fmt24_r <= regWrData[CTLA_FMT24];
      end
   end

   // Hold refused while a carry is in flight, so counters never freeze mid-carry
   always_ff @(posedge clk_sys) begin
      if (sys_rst || srst_r) begin
         hold_r <= 1'b0;
      end else if (wrB) begin
         hold_r <= regWrData[CTLB_HOLD] && !busy;
      end
   end

   // ****************************************
   // Crystal clock sampling and divider
   // ****************************************
   logic                slowS1_r;
   logic                slowS2_r;
   logic                slowS3_r;
   logic [DIV_BITS-1:0] div_r;
   logic                runDiv;

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         slowS1_r <= 1'b0;
         slowS2_r <= 1'b0;
         slowS3_r <= 1'b0;
      end else begin
         slowS1_r <= slowClkPin;
         slowS2_r <= slowS1_r;
         slowS3_r <= slowS2_r;
      end
   end

   assign runDiv = slowS2_r && !slowS3_r && cce_r && !srst_r;
   assign tick   = runDiv && div_r[0] && !stop_r && (&div_r[DIV_BITS-1:1]);

   always_ff @(posedge clk_sys) begin
      if (sys_rst || srst_r) begin
         div_r <= '0;
      end else if (runDiv) begin
         div_r[0] <= ~div_r[0];
         if (div_r[0] && !stop_r) begin
            div_r[DIV_BITS-1:1] <= div_r[DIV_BITS-1:1] + 1'b1;
         end
      end
   end

   // ****************************************
   // Carry busy, hold catch-up and rounding
   // ****************************************
   // Only one second is remembered while counting is blocked
   // A hold write in flight blocks too, so busy never rises under a fresh hold
   assign incSec = (tick || pend_r) && !hold_r && !round_r && !roundStart && !ctrWr
                && !(wrB && regWrData[CTLB_HOLD]);

   always_ff @(posedge clk_sys) begin
      if (sys_rst || srst_r) begin
         pend_r <= 1'b0;
      end else if (incSec) begin
         pend_r <= 1'b0;
      end else if (tick) begin
         pend_r <= 1'b1;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst || srst_r || hold_r) begin
         busyCnt_r <= 16'h0000;
      end else if (incSec) begin
         busyCnt_r <= CARRY_LOAD;
      end else if (busy) begin
         busyCnt_r <= busyCnt_r - 16'h0001;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         round_r    <= 1'b0;
         roundCnt_r <= 16'h0000;
      end else if (roundStart) begin
         round_r    <= 1'b1;
         roundCnt_r <= CARRY_LOAD;
      end else if (round_r) begin
         if (roundCnt_r == 16'h0000) begin
            round_r <= 1'b0;
         end else begin
            roundCnt_r <= roundCnt_r - 16'h0001;
         end
      end
   end

   // ****************************************
   // Calendar advance
   // ****************************************
   rtcc_time_t time_r;
   rtcc_time_t timeNxt;
   rtcc_time_t snap_buf_r;
   logic [5:0] daysInMonth;
   logic       leap;
   logic       cMin;
   logic       cHour;
   logic       cDay;
   logic       cMon;
   logic       cYear;

   // Works on BCD digits directly; tens odd needs units 2 or 6
   always_comb begin
      leap = (!time_r.yrH[0] && (time_r.yrL == 4'h0 || time_r.yrL == 4'h4 || time_r.yrL == 4'h8))
          || (time_r.yrH[0] && (time_r.yrL == 4'h2 || time_r.yrL == 4'h6));
      if (time_r.yrH == 4'h0 && time_r.yrL == 4'h0) begin
         leap = 1'b0;
      end
      case ({time_r.monH, time_r.monL})
         5'h02: daysInMonth = leap ? 6'h29 : 6'h28;
         5'h04, 5'h06, 5'h09, 5'h11: daysInMonth = 6'h30;
         default: daysInMonth = 6'h31;
      endcase
   end

   always_comb begin
      timeNxt = time_r;
      cMin    = roundStart && time_r.secH >= 3'h3;
      cHour   = 1'b0;
      cDay    = 1'b0;
      cMon    = 1'b0;
      cYear   = 1'b0;
      if (roundStart) begin
         timeNxt.secL = 4'h0;
         timeNxt.secH = 3'h0;
      end else if (incSec) begin
         if (time_r.secL == 4'h9) begin
            timeNxt.secL = 4'h0;
            if (time_r.secH == 3'h5) begin
               timeNxt.secH = 3'h0;
               cMin         = 1'b1;
            end else begin
               timeNxt.secH = time_r.secH + 3'h1;
            end
         end else begin
            timeNxt.secL = time_r.secL + 4'h1;
         end
      end
      if (cMin) begin
         if (time_r.minL == 4'h9) begin
            timeNxt.minL = 4'h0;
            if (time_r.minH == 3'h5) begin
               timeNxt.minH = 3'h0;
               cHour        = 1'b1;
            end else begin
               timeNxt.minH = time_r.minH + 3'h1;
            end
         end else begin
            timeNxt.minL = time_r.minL + 4'h1;
         end
      end
      if (cHour) begin
         if ({time_r.hrH, time_r.hrL} == (fmt24_r ? 6'h23 : 6'h11)) begin
            timeNxt.hrH = 2'h0;
            timeNxt.hrL = 4'h0;
            timeNxt.pm  = !fmt24_r && !time_r.pm;
            cDay        = fmt24_r || time_r.pm;
         end else if (time_r.hrL == 4'h9) begin
            timeNxt.hrL = 4'h0;
            timeNxt.hrH = time_r.hrH + 2'h1;
         end else begin
            timeNxt.hrL = time_r.hrL + 4'h1;
         end
      end
      if (cDay) begin
         timeNxt.wk = (time_r.wk >= 3'h6) ? 3'h0 : time_r.wk + 3'h1;
         if ({time_r.dayH, time_r.dayL} >= daysInMonth) begin
            timeNxt.dayH = 2'h0;
            timeNxt.dayL = 4'h1;
            cMon         = 1'b1;
         end else if (time_r.dayL == 4'h9) begin
            timeNxt.dayL = 4'h0;
            timeNxt.dayH = time_r.dayH + 2'h1;
         end else begin
            timeNxt.dayL = time_r.dayL + 4'h1;
         end
      end
      if (cMon) begin
         if ({time_r.monH, time_r.monL} >= 5'h12) begin
            timeNxt.monH = 1'b0;
            timeNxt.monL = 4'h1;
            cYear        = 1'b1;
         end else if (time_r.monL == 4'h9) begin
            timeNxt.monL = 4'h0;
            timeNxt.monH = 1'b1;
         end else begin
            timeNxt.monL = time_r.monL + 4'h1;
         end
      end
      if (cYear) begin
         if (time_r.yrL == 4'h9) begin
            timeNxt.yrL = 4'h0;
            timeNxt.yrH = (time_r.yrH == 4'h9) ? 4'h0 : time_r.yrH + 4'h1;
         end else begin
            timeNxt.yrL = time_r.yrL + 4'h1;
         end
      end
      if (fmt24_r) begin
         timeNxt.pm = 1'b0;
      end
   end

   // Counters accept writes at any time; busy checks are software's job
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         time_r <= '0;
      end else if (ctrWr) begin
         case (regAddr)
            ADDR_SEC: {time_r.secH, time_r.secL} <= regWrData[6:0];
            ADDR_MIN: {time_r.minH, time_r.minL} <= regWrData[6:0];
            ADDR_HOUR: begin
               {time_r.hrH, time_r.hrL} <= regWrData[5:0];
               time_r.pm <= regWrData[HOUR_PM] && !fmt24_r;
            end
            ADDR_DAY: {time_r.dayH, time_r.dayL} <= regWrData[5:0];
            ADDR_MONTH: {time_r.monH, time_r.monL} <= regWrData[4:0];
            ADDR_YEAR: {time_r.yrH, time_r.yrL} <= regWrData;
            ADDR_WEEK: time_r.wk <= regWrData[2:0];
            default: time_r <= time_r;
         endcase
      end else begin
         time_r <= timeNxt;
      end
   end

   // ****************************************
   // Read snapshot and read port
   // ****************************************
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         snap_r     <= 1'b0;
         snap_buf_r <= '0;
      end else if (wrB) begin
         snap_r <= regWrData[CTLB_SNAP];
         if (regWrData[CTLB_SNAP] && !snap_r) begin
            snap_buf_r <= time_r;
         end
      end
   end

   rtcc_time_t view;
   assign view = snap_r ? snap_buf_r : time_r;

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         regRdData <= 8'h00;
      end else if (regRd) begin
         case (regAddr)
            ADDR_CLKCTL: regRdData <= {7'h00, cce_r};
            ADDR_IRQMODE: regRdData <= {7'h00, lvlMode_r};
            ADDR_CTLA: regRdData <= {2'h0, round_r, fmt24_r, 2'h0, stop_r, srst_r};
            ADDR_CTLB: regRdData <= {5'h00, snap_r, busy, hold_r};
            ADDR_SEC: regRdData <= {1'b0, view.secH, view.secL};
            ADDR_MIN: regRdData <= {1'b0, view.minH, view.minL};
            ADDR_HOUR: regRdData <= {1'b0, view.pm && !fmt24_r, view.hrH, view.hrL};
            ADDR_DAY: regRdData <= {2'h0, view.dayH, view.dayL};
            ADDR_MONTH: regRdData <= {3'h0, view.monH, view.monL};
            ADDR_YEAR: regRdData <= {view.yrH, view.yrL};
            ADDR_WEEK: regRdData <= {5'h00, view.wk};
            default: regRdData <= 8'h00;
         endcase
      end else begin
         regRdData <= 8'h00;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         irqAllow    <= 1'b0;
         clkSupplyEn <= 1'b0;
      end else begin
         irqAllow    <= cce_r && !srst_r;
         clkSupplyEn <= cce_r;
      end
   end

   // ****************************************
   // Checks
   // ****************************************
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (sys_rst);

   logic rdHour_r;
   always_ff @(posedge clk_sys) begin
      rdHour_r <= regRd && regAddr == ADDR_HOUR;
   end

   a_hold_refused:
      assert property (wrB && regWrData[CTLB_HOLD] && busy |=> !hold_r)
         else $error("hold taken while busy");
   a_hold_no_busy:
      assert property (hold_r |-> !busy)
         else $error("busy during hold");
   a_round_clears:
      assert property (roundStart |=> time_r.secL == 4'h0 && time_r.secH == 3'h0 && round_r)
         else $error("rounding did not clear seconds");
   a_round_ends:
      assert property (round_r && roundCnt_r == 16'h0000 |=> !round_r)
         else $error("rounding flag stuck");
   a_srst_gate:
      assert property (srst_r |=> !irqAllow)
         else $error("irq allowed in soft reset");
   a_srst_div:
      assert property (srst_r |=> div_r == '0)
         else $error("divider not cleared");
   a_stop_freeze:
      assert property (stop_r && !srst_r |=> $stable(div_r[DIV_BITS-1:1]))
         else $error("divider ran while stopped");
   a_low_stage:
      assert property (runDiv && !sys_rst |=> div_r[0] != $past(div_r[0]))
         else $error("first stage halted");
   a_snap_stable:
      assert property (snap_r && !wrB |=> $stable(snap_buf_r))
         else $error("snapshot changed");
   a_pm_24h:
      assert property (rdHour_r && fmt24_r |-> !regRdData[HOUR_PM])
         else $error("meridiem set in 24-hour");
endmodule

// >>> include/rtcc_pkg.sv
package rtcc_pkg;
   // Register offsets
   localparam logic [3:0] ADDR_CLKCTL  = 4'h0;
   localparam logic [3:0] ADDR_IRQMODE = 4'h1;
   localparam logic [3:0] ADDR_CTLA    = 4'h2;
   localparam logic [3:0] ADDR_CTLB    = 4'h3;
   localparam logic [3:0] ADDR_SEC     = 4'h4;
   localparam logic [3:0] ADDR_MIN     = 4'h5;
   localparam logic [3:0] ADDR_HOUR    = 4'h6;
   localparam logic [3:0] ADDR_DAY     = 4'h7;
   localparam logic [3:0] ADDR_MONTH   = 4'h8;
   localparam logic [3:0] ADDR_YEAR    = 4'h9;
   localparam logic [3:0] ADDR_WEEK    = 4'ha;
   // Bit positions
   localparam int CTLA_SRST  = 0;
   localparam int CTLA_STOP  = 1;
   localparam int CTLA_FMT24 = 4;
   localparam int CTLA_ROUND = 5;
   localparam int CTLB_HOLD  = 0;
   localparam int CTLB_BUSY  = 1;
   localparam int CTLB_SNAP  = 2;
   localparam int HOUR_PM    = 6;
   // Timing
   localparam int SYS_CLK_KHZ  = 10000;
   localparam int CARRY_MS     = 4;
   localparam int CARRY_CYCLES = CARRY_MS * SYS_CLK_KHZ;
   localparam int DIV_BITS     = 15;
   // Reset values
   localparam logic [7:0] CTLA_RST = 8'h00;

   typedef struct packed {
      logic [2:0] wk;
      logic [3:0] yrH;
      logic [3:0] yrL;
      logic       monH;
      logic [3:0] monL;
      logic [1:0] dayH;
      logic [3:0] dayL;
      logic       pm;
      logic [1:0] hrH;
      logic [3:0] hrL;
      logic [2:0] minH;
      logic [3:0] minL;
      logic [2:0] secH;
      logic [3:0] secL;
   } rtcc_time_t;
endpackage

// >>> tb/rtc_calendar_control_tb.sv
`timescale 1ns/1ps
module rtc_calendar_control_tb;
   import rtcc_pkg::*;

   // ****************************************
   // Stimulus, observed outputs, model state
   // ****************************************
   logic       clk_sys;
   logic       sys_rst;
   logic       slowClkPin = 1'b0;
   logic [3:0] regAddr;
   logic [7:0] regWrData;
   logic       regWr;
   logic       regRd;
   logic [7:0] regRdData;
   logic       irqAllow;
   logic       clkSupplyEn;
   int         err_total;
   int         samples_checked;
   int         cycles = 0;
   int         seed;
   int         n;
   logic [7:0] mdl [16];
   logic [7:0] rv;
   bit         fmt24;

   rtcc_core #(.CARRY_CYC(20)) DUT (
      .clk_sys     (clk_sys),
      .sys_rst     (sys_rst),
      .slowClkPin  (slowClkPin),
      .regAddr     (regAddr),
      .regWrData   (regWrData),
      .regWr       (regWr),
      .regRd       (regRd),
      .regRdData   (regRdData),
      .irqAllow    (irqAllow),
      .clkSupplyEn (clkSupplyEn)
   );

   initial begin
      clk_sys = 1'b0;
      forever #50 clk_sys = ~clk_sys;
   end

   // Fastest crystal the sampler resolves, so one second fits in the run
   always @(posedge clk_sys) begin
      slowClkPin <= ~slowClkPin;
      cycles <= cycles + 1;
      if (cycles == 90000) begin
         err_total++;
         summarize();
      end
   end

   // ****************************************
   // Bus cycles and comparisons
   // ****************************************
   task automatic summarize();
      $display("Comparisons %0d, mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
      samples_checked++;
      if (s !== e) begin
         err_total++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
      end
   endtask

   task automatic pins(input logic eSup, input logic eIrq);
      @(negedge clk_sys);
      chk("clkSupplyEn", {7'h00, eSup}, {7'h00, clkSupplyEn});
      chk("irqAllow", {7'h00, eIrq}, {7'h00, irqAllow});
      @(posedge clk_sys);
   endtask

   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      regAddr   <= a;
      regWrData <= d;
      regWr     <= 1'b1;
      @(posedge clk_sys);
      regWr <= 1'b0;
      @(posedge clk_sys);
      if (a == ADDR_CTLA) fmt24 = d[CTLA_FMT24];
      if (a >= ADDR_SEC && a <= ADDR_WEEK) begin
         mdl[a] = (a == ADDR_HOUR && fmt24) ? (d & 8'h3f) : d;
         repeat (2) @(posedge clk_sys);
      end
   endtask

   task automatic rd(input logic [3:0] a);
      regAddr <= a;
      regRd   <= 1'b1;
      @(posedge clk_sys);
      regRd <= 1'b0;
      #1 rv = regRdData;
      @(posedge clk_sys);
   endtask

   task automatic rc(input logic [3:0] a, input logic [7:0] e);
      rd(a);
      chk($sformatf("register %h", a), e, rv);
   endtask

   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      seed = 32'h29718028;
      sys_rst = 1'b1;
      regAddr = 4'h0;
      regWrData = 8'h00;
      regWr = 1'b0;
      regRd = 1'b0;
      err_total = 0;
      samples_checked = 0;
      fmt24 = 1'b0;
      foreach (mdl[i]) mdl[i] = 8'h00;
      repeat (4) @(posedge clk_sys);
      sys_rst <= 1'b0;
      @(posedge clk_sys);
      // Unmapped offsets included: they must read 0
      for (n = 0; n < 16; n++) rc(4'(n), 8'h00);
      pins(1'b0, 1'b0);

      // Supply gate and soft reset
      wr(ADDR_CLKCTL, 8'h01);
      pins(1'b1, 1'b1);
      wr(ADDR_CTLB, 8'h01);
      wr(ADDR_CTLA, 8'h01);
      pins(1'b1, 1'b0);
      rc(ADDR_CTLB, 8'h00);
      wr(ADDR_CTLA, 8'h00);
      pins(1'b1, 1'b1);
      wr(ADDR_CLKCTL, 8'h00);
      pins(1'b0, 1'b0);
      wr(ADDR_IRQMODE, 8'h01);
      rc(ADDR_IRQMODE, 8'h01);

      // Meridiem flag in both hour formats
      wr(ADDR_CTLA, 8'h02);
      wr(ADDR_CTLB, 8'h01);
      rc(ADDR_CTLB, 8'h01);
      wr(ADDR_HOUR, 8'h51);
      rc(ADDR_HOUR, mdl[ADDR_HOUR]);
      wr(ADDR_CTLA, 8'h12);
      wr(ADDR_HOUR, 8'h51);
      rc(ADDR_HOUR, mdl[ADDR_HOUR]);
      wr(ADDR_HOUR, 8'h23);
      rc(ADDR_HOUR, mdl[ADDR_HOUR]);
      wr(ADDR_CTLB, 8'h00);

      // Rounding with tens of seconds at 2, 3 and 4
      for (n = 0; n < 3; n++) begin
         wr(ADDR_SEC, {1'b0, 3'(2 + n), 4'($unsigned($random(seed)) % 10)});
         wr(ADDR_MIN, {4'h1, 4'($unsigned($random(seed)) % 9)});
         rc(ADDR_SEC, mdl[ADDR_SEC]);
         rc(ADDR_CTLB, 8'h00);
         wr(ADDR_CTLA, 8'h32);
         rc(ADDR_CTLA, 8'h32);
         for (int k = 0; k < 15 && rv[CTLA_ROUND]; k++) rd(ADDR_CTLA);
         chk("round flag", 8'h12, rv);
         mdl[ADDR_SEC] = 8'h00;
         if (n > 0) mdl[ADDR_MIN] = mdl[ADDR_MIN] + 8'h01;
         rc(ADDR_SEC, mdl[ADDR_SEC]);
         rc(ADDR_MIN, mdl[ADDR_MIN]);
      end

      // One second from 11:59:59 pm on a nonexistent day 31 of month 4
      wr(ADDR_CTLA, 8'h02);
      wr(ADDR_CTLB, 8'h01);
      wr(ADDR_SEC, 8'h59);
      wr(ADDR_MIN, 8'h59);
      wr(ADDR_HOUR, 8'h51);
      wr(ADDR_DAY, 8'h31);
      wr(ADDR_MONTH, 8'h04);
      wr(ADDR_YEAR, {4'h4, 4'($unsigned($random(seed)) % 10)});
      wr(ADDR_WEEK, 8'h06);
      wr(ADDR_CTLB, 8'h00);
      wr(ADDR_CLKCTL, 8'h01);
      wr(ADDR_CTLA, 8'h00);
      wr(ADDR_CTLB, 8'h04);
      rd(ADDR_CTLB);
      for (n = 0; n < 36000 && !rv[CTLB_BUSY]; n++) rd(ADDR_CTLB);
      chk("busy flag", 8'h06, rv);
      // Hold must be refused while the carry runs
      wr(ADDR_CTLB, 8'h05);
      rc(ADDR_CTLB, 8'h06);
      for (n = 0; n < 15 && rv[CTLB_BUSY]; n++) rd(ADDR_CTLB);
      chk("busy flag", 8'h04, rv);
      rc(ADDR_SEC, 8'h59);
      rc(ADDR_DAY, 8'h31);
      wr(ADDR_CTLB, 8'h00);
      rc(ADDR_SEC, 8'h00);
      rc(ADDR_MIN, 8'h00);
      rc(ADDR_HOUR, 8'h00);
      rc(ADDR_DAY, 8'h01);
      rc(ADDR_MONTH, 8'h05);
      rc(ADDR_YEAR, mdl[ADDR_YEAR]);
      rc(ADDR_WEEK, 8'h00);
      summarize();
   end
endmodule
